//--- verilog/owc_pkg.sv
// package: register map, field layout and reset values of the oscillator control block
package owc_pkg;
	localparam logic [3:0] ADDR_OSC_CTRL = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h0;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
	localparam logic [3:0] ADDR_LP_CTRL = 4'hC;
	localparam int PRE_HI = 31;
	localparam int PRE_LO = 20;
	localparam int B_WU_CLK = 19;
	localparam int B_EXT_SRC = 18;
	localparam int B_OSC_SEL = 17;
	localparam int B_INT_EN = 16;
	localparam int B_IN_USE = 9;
	localparam int B_EXT_EN = 8;
	localparam int B_MUL_EN = 2;
	localparam int B_WU_ACT = 1;
	localparam int B_WU_GO = 0;
	localparam logic [31:0] OSC_CTRL_RESET = 32'h8001_0030;
	// reserved fields: 15-10 write-0, 7-3 write 00110; these hold their reset pattern
	localparam logic [31:0] RSVD_MASK = 32'h0000_FCF8;
	localparam logic [31:0] RSVD_VALUE = 32'h0000_0030;
	localparam logic [3:0] LOW_NIBBLE_PRELOAD = 4'h0;
	localparam int IRQ_WU_DONE = 0;
	localparam int IRQ_WU_START = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic [11:0] preload_upper;
		logic warmup_clock_select;
		logic external_source_select;
		logic high_speed_osc_select;
		logic internal_osc_enable;
		logic external_osc_enable;
		logic multiplier_enable;
		logic multiplied_clock_use;
	} owc_ctrl_t;
	typedef struct packed {
		logic internal_osc_run;
		logic external_crystal_run;
		logic multiplier_run;
		logic external_source_is_crystal;
		logic high_speed_is_external;
		logic multiplied_clock_use;
	} owc_clk_out_t;
endpackage : owc_pkg

//--- verilog/owc_warmup_timer.sv
// warm-up counter clocked by ref_clk, counting ticks of the selected oscillator
`timescale 1ns/1ns
module owc_warmup_timer (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic start,
	input wire logic [15:0] preload,
	input wire logic tick,
	output logic active,
	output logic done
);
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic active_q;
	logic active_d;
	logic done_q;
	wire logic reach = active_q && tick && (count_q + 16'h0001 >= preload);
	always_comb begin
		count_d = count_q;
		active_d = active_q;
		if (start) begin
			count_d = 16'h0000;
			active_d = 1'b1;
		end else if (active_q && tick) begin
			count_d = count_q + 16'h0001;
			if (reach) begin
				active_d = 1'b0;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			count_q <= 16'h0000;
			active_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			count_q <= count_d;
			active_q <= active_d;
			done_q <= reach && !start;
		end
	end
	assign active = active_q;
	assign done = done_q;
endmodule : owc_warmup_timer

//--- verilog/owc_axil_slave.sv
// AXI4-Lite slave front end: takes one write and one read, answers from registers
`timescale 1ns/1ns
module owc_axil_slave (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [31:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [31:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output logic wr_en,
	output logic [3:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic rd_en,
	output logic [3:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
	logic aw_q;
	logic w_q;
	logic [3:0] awa_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic bv_q;
	logic [1:0] br_q;
	logic rv_q;
	logic [31:0] rd_q;
	logic [1:0] rr_q;
	assign s_awready = !aw_q && !bv_q;
	assign s_wready = !w_q && !bv_q;
	assign s_arready = !rv_q;
	assign wr_en = aw_q && w_q && !bv_q;
	assign wr_addr = awa_q;
	assign wr_data = wd_q;
	assign wr_strb = ws_q;
	assign rd_en = s_arvalid && s_arready;
	// any high address bit maps to an unused code, so aliases are refused
	assign rd_addr = (|s_araddr[31:4]) ? 4'h1 : s_araddr[3:0];
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 4'h0;
			wd_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			bv_q <= 1'b0;
			br_q <= 2'h0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_q <= 1'b1;
				awa_q <= (|s_awaddr[31:4]) ? 4'h1 : s_awaddr[3:0];
			end
			if (s_wvalid && s_wready) begin
				w_q <= 1'b1;
				wd_q <= s_wdata;
				ws_q <= s_wstrb;
			end
			if (wr_en) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				bv_q <= 1'b1;
				br_q <= wr_ok ? owc_pkg::RESP_OKAY : owc_pkg::RESP_SLVERR;
			end else if (bv_q && s_bready) begin
				bv_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rv_q <= 1'b0;
			rd_q <= 32'h0000_0000;
			rr_q <= 2'h0;
		end else if (rd_en) begin
			rv_q <= 1'b1;
			rd_q <= rd_ok ? rd_data : 32'h0000_0000;
			rr_q <= rd_ok ? owc_pkg::RESP_OKAY : owc_pkg::RESP_SLVERR;
		end else if (rv_q && s_rready) begin
			rv_q <= 1'b0;
		end
	end
	assign s_bvalid = bv_q;
	assign s_bresp = br_q;
	assign s_rvalid = rv_q;
	assign s_rdata = rd_q;
	assign s_rresp = rr_q;
endmodule : owc_axil_slave

//--- verilog/owc_osc_control.sv
// oscillator control register, warm-up control, interrupt and low-power registers
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module owc_osc_control (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [31:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [31:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic internal_osc_tick,
	input wire logic external_osc_tick,
	input wire logic deep_stop_exit,
	output owc_pkg::owc_clk_out_t clk_ctrl,
	output logic irq
);
	owc_pkg::owc_ctrl_t ctrl_q;
	owc_pkg::owc_ctrl_t ctrl_d;
	logic in_use_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic wr_en;
	logic [3:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic rd_en;
	logic [3:0] rd_addr;
	logic [31:0] rd_word;
	logic wu_active;
	logic wu_done;

	function automatic logic [31:0] strobe_mask(input logic [3:0] s);
		strobe_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : strobe_mask

	function automatic logic addr_known(input logic [3:0] a);
		addr_known = (a == owc_pkg::ADDR_OSC_CTRL) || (a == owc_pkg::ADDR_IRQ_STATUS) ||
			(a == owc_pkg::ADDR_IRQ_MASK) || (a == owc_pkg::ADDR_LP_CTRL);
	endfunction : addr_known

	owc_axil_slave u_bus (
		.ref_clk(ref_clk),
		.srst(srst),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(addr_known(wr_addr)),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_word),
		.rd_ok(addr_known(rd_addr))
	);

	wire logic [31:0] wmask = strobe_mask(wr_strb);
	wire logic wr_osc = wr_en && (wr_addr == owc_pkg::ADDR_OSC_CTRL);
	wire logic wr_mask = wr_en && (wr_addr == owc_pkg::ADDR_IRQ_MASK);
	wire logic wr_lp = wr_en && (wr_addr == owc_pkg::ADDR_LP_CTRL);
	wire logic [31:0] cur_word = osc_word(ctrl_q, in_use_q, wu_active);
	// bytes whose write strobe is clear keep the current value whatever is written
	wire logic [31:0] merged = (cur_word & ~wmask) | (wr_data & wmask);
	wire logic wu_start = wr_osc && wmask[owc_pkg::B_WU_GO] && wr_data[owc_pkg::B_WU_GO];
	wire logic wu_tick = ctrl_q.warmup_clock_select ? external_osc_tick : internal_osc_tick;
	wire logic [15:0] wu_preload = {ctrl_q.preload_upper, owc_pkg::LOW_NIBBLE_PRELOAD};

	function automatic logic [31:0] osc_word(input owc_pkg::owc_ctrl_t c, input logic use_ext,
		input logic act);
		logic [31:0] w;
		w = owc_pkg::RSVD_VALUE;
		w[owc_pkg::PRE_HI:owc_pkg::PRE_LO] = c.preload_upper;
		w[owc_pkg::B_WU_CLK] = c.warmup_clock_select;
		w[owc_pkg::B_EXT_SRC] = c.external_source_select;
		w[owc_pkg::B_OSC_SEL] = c.high_speed_osc_select;
		w[owc_pkg::B_INT_EN] = c.internal_osc_enable;
		w[owc_pkg::B_IN_USE] = use_ext;
		w[owc_pkg::B_EXT_EN] = c.external_osc_enable;
		w[owc_pkg::B_MUL_EN] = c.multiplier_enable;
		w[owc_pkg::B_WU_ACT] = act;
		w[owc_pkg::B_WU_GO] = 1'b0;
		osc_word = w;
	endfunction : osc_word

	assign rd_word =
		(rd_addr == owc_pkg::ADDR_OSC_CTRL) ? cur_word :
		(rd_addr == owc_pkg::ADDR_IRQ_STATUS) ? {30'h0000_0000, irq_stat_q} :
		(rd_addr == owc_pkg::ADDR_IRQ_MASK) ? {30'h0000_0000, irq_mask_q} :
		(rd_addr == owc_pkg::ADDR_LP_CTRL) ? {31'h0000_0000, ctrl_q.multiplied_clock_use} :
		32'h0000_0000;

	owc_warmup_timer u_warmup (
		.ref_clk(ref_clk),
		.srst(srst),
		.start(wu_start),
		.preload(wu_preload),
		.tick(wu_tick),
		.active(wu_active),
		.done(wu_done)
	);

	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_osc) begin
			ctrl_d.preload_upper = merged[owc_pkg::PRE_HI:owc_pkg::PRE_LO];
			ctrl_d.warmup_clock_select = merged[owc_pkg::B_WU_CLK];
			ctrl_d.external_source_select = merged[owc_pkg::B_EXT_SRC];
			ctrl_d.high_speed_osc_select = merged[owc_pkg::B_OSC_SEL];
			ctrl_d.internal_osc_enable = merged[owc_pkg::B_INT_EN];
			ctrl_d.external_osc_enable = merged[owc_pkg::B_EXT_EN];
			ctrl_d.multiplier_enable = merged[owc_pkg::B_MUL_EN];
		end
		if (wr_lp && wmask[0]) begin
			ctrl_d.multiplied_clock_use = wr_data[0];
		end
		if (deep_stop_exit) begin
			ctrl_d.warmup_clock_select = 1'b0;
			ctrl_d.high_speed_osc_select = 1'b0;
			ctrl_d.internal_osc_enable = 1'b1;
			ctrl_d.external_osc_enable = 1'b0;
			ctrl_d.multiplier_enable = 1'b0;
			ctrl_d.multiplied_clock_use = 1'b0;
		end
	end

	wire logic rd_stat = rd_en && (rd_addr == owc_pkg::ADDR_IRQ_STATUS);
	wire logic [1:0] irq_events = {wu_start, wu_done};

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_q <= '{preload_upper: 12'h800, internal_osc_enable: 1'b1, default: 1'b0};
			in_use_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			in_use_q <= ctrl_q.high_speed_osc_select;
		end
	end

	// set wins over the read-to-clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_stat_q <= 2'h0;
			irq_mask_q <= 2'h0;
		end else begin
			irq_stat_q <= (rd_stat ? 2'h0 : irq_stat_q) | irq_events;
			if (wr_mask && wmask[0]) begin
				irq_mask_q <= wr_data[1:0];
			end
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);
	assign clk_ctrl.internal_osc_run = ctrl_q.internal_osc_enable;
	assign clk_ctrl.external_crystal_run = ctrl_q.external_osc_enable;
	assign clk_ctrl.multiplier_run = ctrl_q.multiplier_enable;
	assign clk_ctrl.external_source_is_crystal = ctrl_q.external_source_select;
	assign clk_ctrl.high_speed_is_external = ctrl_q.high_speed_osc_select;
	assign clk_ctrl.multiplied_clock_use = ctrl_q.multiplied_clock_use;
endmodule : owc_osc_control

//--- testbench/owc_osc_control_checker.sv
// port assertions and covers for the oscillator control block
`timescale 1ns/1ns
module owc_osc_control_checker (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [31:0] s_awaddr,
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic [1:0] s_bresp,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic [31:0] s_araddr,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic [31:0] s_rdata,
	input wire logic [1:0] s_rresp,
	input wire logic s_rvalid,
	input wire logic s_rready,
	input wire logic internal_osc_tick,
	input wire logic external_osc_tick,
	input wire logic deep_stop_exit,
	input wire owc_pkg::owc_clk_out_t clk_ctrl,
	input wire logic irq
);
	logic [31:0] ra_q;
	// address of the read being answered
	always_ff @(posedge ref_clk) begin
		if (s_arvalid && s_arready) ra_q <= s_araddr;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	chk_read_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
		else $error("read answer dropped or changed before rready");
	chk_write_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
		else $error("write answer dropped or changed before bready");
	chk_ar_ready: assert property (s_arready != s_rvalid)
		else $error("arready not the inverse of rvalid");
	chk_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
		else $error("read answer late");
	chk_write_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
		else $error("write answer late");
	chk_start_reads_zero: assert property (s_rvalid && ra_q == 32'h4 |->
		s_rdata[0] == 1'h0 && s_rdata[15:10] == 6'h00 && s_rdata[7:3] == 5'h06)
		else $error("start bit or reserved bits read wrong");
	chk_unmapped_err: assert property (s_rvalid && ra_q[31:4] != 28'h0 |->
		s_rresp == owc_pkg::RESP_SLVERR && s_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_stop_reinit: assert property (deep_stop_exit |-> ##[1:2] (clk_ctrl.internal_osc_run &&
		!clk_ctrl.external_crystal_run && !clk_ctrl.multiplier_run &&
		!clk_ctrl.high_speed_is_external && !clk_ctrl.multiplied_clock_use))
		else $error("deep stop exit did not reinitialise clocks");
	chk_reset_state: assert property (disable iff (1'h0) srst |=>
		clk_ctrl == 6'h20 && !irq && !s_rvalid && !s_bvalid)
		else $error("reset state wrong");
	cov_irq_rise: cover property ($rose(irq));
	cov_slverr: cover property (s_rvalid && s_rresp == owc_pkg::RESP_SLVERR);
	cov_stop_exit: cover property (deep_stop_exit);
endmodule : owc_osc_control_checker

//--- testbench/owc_osc_control_tb.sv
// self-checking bench of the oscillator control block
`timescale 1ns/1ns
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module owc_osc_control_tb;
	logic ref_clk, srst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, irq;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic internal_osc_tick, external_osc_tick, deep_stop_exit;
	logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, rd;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp, rs;
	owc_pkg::owc_clk_out_t clk_ctrl;
	int error_cnt = 0;
	int tests_run = 0;
	owc_osc_control u_owc_osc_control (.*);
	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic summarize;
		$display("mismatches %0d of %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	// handshakes are judged mid-cycle, where the ports have settled
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ah, wh, bv;
		@(posedge ref_clk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'h1;
		s_wvalid <= 1'h1;
		s_bready <= 1'h1;
		do begin
			@(negedge ref_clk);
			ah = s_awvalid && s_awready;
			wh = s_wvalid && s_wready;
			bv = s_bvalid;
			r = s_bresp;
			@(posedge ref_clk);
			if (ah) s_awvalid <= 1'h0;
			if (wh) s_wvalid <= 1'h0;
		end while (!bv);
		s_bready <= 1'h0;
	endtask : wr
	task automatic rdb(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah, rv;
		@(posedge ref_clk);
		s_araddr <= a;
		s_arvalid <= 1'h1;
		s_rready <= 1'h1;
		do begin
			@(negedge ref_clk);
			ah = s_arvalid && s_arready;
			rv = s_rvalid;
			d = s_rdata;
			r = s_rresp;
			@(posedge ref_clk);
			if (ah) s_arvalid <= 1'h0;
		end while (!rv);
		s_rready <= 1'h0;
	endtask : rdb
	task automatic wrc(input logic [31:0] a, input logic [31:0] d);
		wr(a, d, rs);
		`CHK("bresp", owc_pkg::RESP_OKAY, rs)
	endtask : wrc
	task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string n);
		rdb(a, rd, rs);
		`CHK("rresp", owc_pkg::RESP_OKAY, rs)
		`CHK(n, e, rd)
	endtask : rdc
	task automatic tk(input logic e, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			external_osc_tick <= e;
			internal_osc_tick <= !e;
			@(posedge ref_clk);
			external_osc_tick <= 1'h0;
			internal_osc_tick <= 1'h0;
		end
	endtask : tk
	task automatic t_reset;
		rdc(32'h4, 32'h8001_0030, "reset value");
		`CHK("reset clocks", 6'h20, clk_ctrl)
		`CHK("reset irq", 1'h0, irq)
	endtask : t_reset
	task automatic t_fields;
		// source select first, oscillator select in a later write
		wrc(32'h4, 32'h8005_0130);
		rdc(32'h4, 32'h8005_0130, "crystal on");
		`CHK("crystal clocks", 6'h34, clk_ctrl)
		wrc(32'h4, 32'h800F_0134);
		rdc(32'h4, 32'h800F_0334, "external sel");
		`CHK("external clocks", 6'h3E, clk_ctrl)
		wrc(32'h4, 32'h800F_FDCC);
		rdc(32'h4, 32'h800F_0334, "reserved");
		`CHK("reserved clocks", 6'h3E, clk_ctrl)
		wrc(32'hC, 32'h1);
		rdc(32'hC, 32'h1, "use mult");
		`CHK("use clocks", 6'h3F, clk_ctrl)
	endtask : t_fields
	task automatic t_stop;
		@(posedge ref_clk);
		deep_stop_exit <= 1'h1;
		@(posedge ref_clk);
		deep_stop_exit <= 1'h0;
		repeat (2) @(posedge ref_clk);
		`CHK("stop clocks", 6'h24, clk_ctrl)
		rdc(32'h4, 32'h8005_0030, "stop value");
		rdc(32'hC, 32'h0, "stop use");
	endtask : t_stop
	task automatic t_warm(input logic sel);
		logic [31:0] b;
		b = {12'h001, sel, 3'h1, 16'h0030};
		wrc(32'h8, 32'h1);
		wrc(32'h4, b);
		rdc(32'h4, b, "zero start");
		wrc(32'h4, b | 32'h1);
		rdc(32'h4, b | 32'h2, "started");
		`CHK("masked irq", 1'h0, irq)
		tk(!sel, 20);
		rdc(32'h4, b | 32'h2, "other clock");
		tk(sel, 15);
		rdc(32'h4, b | 32'h2, "one short");
		tk(sel, 1);
		rdc(32'h4, b, "warm done");
		`CHK("done irq", 1'h1, irq)
		rdc(32'h0, 32'h3, "status");
		repeat (2) @(posedge ref_clk);
		`CHK("cleared irq", 1'h0, irq)
		rdc(32'h0, 32'h0, "status clear");
	endtask : t_warm
	task automatic t_unmapped;
		wr(32'h10, 32'hFFFF_FFFF, rs);
		`CHK("bad write", owc_pkg::RESP_SLVERR, rs)
		rdb(32'h10, rd, rs);
		`CHK("bad read", owc_pkg::RESP_SLVERR, rs)
		`CHK("bad data", 32'h0, rd)
	endtask : t_unmapped
	initial begin
		srst = 1'h1;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		{internal_osc_tick, external_osc_tick, deep_stop_exit} = 3'h0;
		s_awaddr = 32'h0;
		s_wdata = 32'h0;
		s_araddr = 32'h0;
		s_wstrb = 4'hF;
		repeat (2) @(posedge ref_clk);
		srst <= 1'h0;
		t_reset;
		t_fields;
		t_stop;
		t_warm(1'h0);
		t_warm(1'h1);
		t_unmapped;
		summarize;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		error_cnt++;
		summarize;
	end
endmodule : owc_osc_control_tb
bind owc_osc_control owc_osc_control_checker u_owc_osc_control_checker (.*);
